/* rtl/hpd_core.v */
// serial target interface, register store and power-mode control
`timescale 1ns/1ps
`default_nettype none
`include "hpd_defs.vh"
module hpd_core #(
  parameter DEPTH = `HPD_REG_DEPTH
) (
  input wire clk, // 25 MHz system clock
  input wire reset, // power-on reset, async, active high
  input wire enable_pin, // high = powered, low = shutdown
  input wire low_power_hold_pin, // high = standby
  input wire supply_ok, // supply valid
  input wire scl_in, // serial clock pin level
  input wire sda_in, // serial data pin level
  output wire sda_out, // serial data drive value, always low
  output wire sda_oe_n, // low while pulling data line low
  output reg [1:0] power_mode, // off, hold or active
  output reg output_hiz, // output stage released
  output reg blocks_on, // full internal power
  output reg wake_ready, // quick-wake circuits powered
  output reg gain_path_on // output follows input times gain
);
  // ----------------------------------------------------------------
  // input synchronisation
  // ----------------------------------------------------------------
  wire [3:0] sync_q;
  hpd_sync #(.WIDTH(4)) u_sync (
    .clk(clk),
    .reset(reset),
    .din({scl_in, sda_in, enable_pin, low_power_hold_pin}),
    .dout(sync_q)
  );
  wire scl_s = sync_q[3];
  wire sda_s = sync_q[2];
  wire en_s = sync_q[1];
  wire hold_s = sync_q[0];

  reg scl_d;
  reg sda_d;
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_ev = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_ev = scl_s & scl_d & ~sda_d & sda_s;

  // ----------------------------------------------------------------
  // power modes
  // ----------------------------------------------------------------
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      power_mode <= `HPD_MODE_OFF;
      output_hiz <= 1'b1;
      blocks_on <= 1'b0;
      wake_ready <= 1'b0;
      gain_path_on <= 1'b0;
    end else if (!en_s) begin
      power_mode <= `HPD_MODE_OFF;
      output_hiz <= 1'b1;
      blocks_on <= 1'b0;
      wake_ready <= 1'b0;
      gain_path_on <= 1'b0;
    end else if (hold_s) begin
      power_mode <= `HPD_MODE_HOLD;
      output_hiz <= 1'b1;
      blocks_on <= 1'b0;
      wake_ready <= 1'b1;
      gain_path_on <= 1'b0;
    end else begin
      power_mode <= supply_ok ? `HPD_MODE_ACTIVE : `HPD_MODE_HOLD;
      output_hiz <= ~supply_ok;
      blocks_on <= supply_ok;
      wake_ready <= 1'b1;
      gain_path_on <= supply_ok;
    end
  end

  // ----------------------------------------------------------------
  // register store
  // ----------------------------------------------------------------
  // small and flat: each write lands in one addressed byte
  reg [7:0] regs [0:DEPTH-1];
  reg [7:0] ptr;
  reg [7:0] shift;
  reg [3:0] bit_cnt;
  reg [2:0] state;
  reg [2:0] after_ack;
  reg is_read;
  reg ptr_loaded;
  reg drive_low;
  reg wr_en;
  reg [7:0] wr_addr;
  reg [7:0] wr_data;
  integer i;

  // defaults restored on reset or shutdown
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        regs[i] <= `HPD_REG_RESET;
      end
    end else if (!en_s) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        regs[i] <= `HPD_REG_RESET;
      end
    end else if (wr_en) begin
      regs[wr_addr] <= wr_data;
    end
  end

  function addr_match;
    input [7:0] b;
    begin
      addr_match = (b[7:1] == `HPD_ADDR7);
    end
  endfunction

  // ----------------------------------------------------------------
  // serial target state machine
  // ----------------------------------------------------------------
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= `HPD_ST_IDLE;
      after_ack <= `HPD_ST_IDLE;
      shift <= 8'h00;
      bit_cnt <= 4'h0;
      ptr <= 8'h00;
      is_read <= 1'b0;
      ptr_loaded <= 1'b0;
      drive_low <= 1'b0;
      wr_en <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
    end else begin
      wr_en <= 1'b0;
      if (!en_s) begin
        state <= `HPD_ST_IDLE;
        drive_low <= 1'b0;
        ptr <= 8'h00;
      end else if (start_ev) begin
        state <= `HPD_ST_ADDR;
        bit_cnt <= 4'h0;
        drive_low <= 1'b0;
      end else if (stop_ev) begin
        state <= `HPD_ST_IDLE;
        drive_low <= 1'b0;
      end else begin
        case (state)
          `HPD_ST_IDLE, `HPD_ST_IGNORE: begin
            drive_low <= 1'b0;
          end
          `HPD_ST_ADDR, `HPD_ST_WRBYTE: begin
            if (scl_rise) begin
              shift <= {shift[6:0], sda_s};
              bit_cnt <= bit_cnt + 4'h1;
            end
            if (scl_fall && bit_cnt == `HPD_BITS) begin
              bit_cnt <= 4'h0;
              if (state == `HPD_ST_ADDR) begin
                if (addr_match(shift)) begin
                  drive_low <= 1'b1;
                  is_read <= shift[0];
                  state <= `HPD_ST_ACK;
                  after_ack <= shift[0] ? `HPD_ST_RDBYTE : `HPD_ST_WRBYTE;
                  ptr_loaded <= 1'b0;
                end else begin
                  state <= `HPD_ST_IGNORE;
                end
              end else begin
                drive_low <= 1'b1;
                state <= `HPD_ST_ACK;
                after_ack <= `HPD_ST_WRBYTE;
                if (!ptr_loaded) begin
                  ptr <= shift;
                  ptr_loaded <= 1'b1;
                end else begin
                  wr_en <= 1'b1;
                  wr_addr <= ptr;
                  wr_data <= shift;
                  ptr <= ptr + 8'h01;
                end
              end
            end
          end
          `HPD_ST_ACK: begin
            // hold for whole ack clock: low after own ack, released after host ack
            if (scl_fall) begin
              state <= after_ack;
              bit_cnt <= 4'h0;
              if (after_ack == `HPD_ST_RDBYTE) begin
                shift <= regs[ptr];
                drive_low <= ~regs[ptr][7];
                ptr <= ptr + 8'h01;
                bit_cnt <= 4'h1;
              end else begin
                drive_low <= 1'b0;
              end
            end
          end
          `HPD_ST_RDBYTE: begin
            if (scl_fall) begin
              if (bit_cnt == `HPD_BITS) begin
                drive_low <= 1'b0;
                state <= `HPD_ST_RDACK;
              end else begin
                drive_low <= ~shift[7 - bit_cnt[2:0]];
                bit_cnt <= bit_cnt + 4'h1;
              end
            end
          end
          `HPD_ST_RDACK: begin
            if (scl_rise) begin
              if (sda_s) begin
                state <= `HPD_ST_IGNORE;
              end else begin
                state <= `HPD_ST_ACK;
                after_ack <= `HPD_ST_RDBYTE;
              end
            end
          end
          default: begin
            state <= `HPD_ST_IDLE;
            drive_low <= 1'b0;
          end
        endcase
      end
    end
  end

  // no byte limit: register pointer wraps from FF to 00
  assign sda_out = 1'b0;
  assign sda_oe_n = ~drive_low;
endmodule
`default_nettype wire

/* rtl/hpd_defs.vh */
// constants for the haptic driver serial target and power-mode control
`ifndef HPD_DEFS_VH
`define HPD_DEFS_VH
`define HPD_ADDR7 7'h5A
`define HPD_BITS 4'h8
`define HPD_REG_DEPTH 256
`define HPD_REG_RESET 8'h00
`define HPD_ST_IDLE 3'h0
`define HPD_ST_ADDR 3'h1
`define HPD_ST_ACK 3'h2
`define HPD_ST_WRBYTE 3'h3
`define HPD_ST_RDBYTE 3'h4
`define HPD_ST_RDACK 3'h5
`define HPD_ST_IGNORE 3'h6
`define HPD_MODE_OFF 2'h0
`define HPD_MODE_HOLD 2'h1
`define HPD_MODE_ACTIVE 2'h2
`endif

/* rtl/hpd_sync.v */
// two-stage synchroniser for a group of external levels
`timescale 1ns/1ps
`default_nettype none
module hpd_sync #(
  parameter WIDTH = 2
) (
  input wire clk, // system clock
  input wire reset, // async reset, active high
  input wire [WIDTH-1:0] din, // asynchronous levels
  output reg [WIDTH-1:0] dout // synchronised levels
);
  reg [WIDTH-1:0] stage1;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      stage1 <= {WIDTH{1'b1}};
      dout <= {WIDTH{1'b1}};
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule
`default_nettype wire

/* testbench/hpd_chk.sv */
// checker for power modes and serial pin drive of the haptic driver core
`timescale 1ns/1ps
`default_nettype none
module hpd_chk (
  input wire logic clk, // clock
  input wire logic reset, // async reset
  input wire logic enable_pin, // enable
  input wire logic low_power_hold_pin, // standby
  input wire logic supply_ok, // supply valid
  input wire logic scl_in, // serial clock
  input wire logic sda_out, // drive value
  input wire logic sda_oe_n, // pull enable
  input wire logic [1:0] power_mode, // mode
  input wire logic output_hiz, // output released
  input wire logic blocks_on, // full power
  input wire logic wake_ready, // quick wake
  input wire logic gain_path_on // gain path
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // five samples cover the two sync stages and the output register
  property p_off; !enable_pin [*5] |-> power_mode == 2'h0 && output_hiz && sda_oe_n; endproperty
  a_off: assert property (p_off) else $error("shutdown state wrong");
  property p_offall; power_mode == 2'h0 |-> !blocks_on && !wake_ready && !gain_path_on; endproperty
  a_offall: assert property (p_offall) else $error("blocks powered in shutdown");
  property p_hold; enable_pin && low_power_hold_pin [*5] |-> power_mode == 2'h1 && wake_ready
    && !blocks_on && !gain_path_on; endproperty
  a_hold: assert property (p_hold) else $error("standby state wrong");
  property p_act; enable_pin && !low_power_hold_pin && supply_ok [*5] |-> power_mode == 2'h2
    && blocks_on && gain_path_on && !output_hiz; endproperty
  a_act: assert property (p_act) else $error("active state wrong");
  property p_bad; enable_pin && !low_power_hold_pin && !supply_ok [*5] |-> output_hiz
    && !gain_path_on; endproperty
  a_bad: assert property (p_bad) else $error("output on without supply");
  property p_gain; gain_path_on |-> power_mode == 2'h2 && blocks_on && !output_hiz; endproperty
  a_gain: assert property (p_gain) else $error("gain path outside active");
  property p_bit; !sda_oe_n && $rose(scl_in) |-> !sda_oe_n [*4]; endproperty
  a_bit: assert property (p_bit) else $error("data released while clock high");
  property p_od; sda_out == 1'b0; endproperty
  a_od: assert property (p_od) else $error("data drive value not low");
  property p_edge; $changed(sda_oe_n) && enable_pin |-> !scl_in; endproperty
  a_edge: assert property (p_edge) else $error("data moved while clock high");
endmodule
bind hpd_core hpd_chk hpd_chk_inst (.*);
`default_nettype wire

/* testbench/hpd_core_tb.sv */
// testbench for the haptic driver serial target and power modes
`timescale 1ns/1ps
`default_nettype none
module hpd_core_tb;
  logic clk, reset, enable_pin, low_power_hold_pin, supply_ok, ak;
  logic [7:0] rd;
  wire logic scl, sda_m, sda_out, sda_oe_n, output_hiz, blocks_on, wake_ready, gain_path_on;
  wire logic [1:0] power_mode;
  wire logic [7:0] flags = {4'h0, output_hiz, blocks_on, wake_ready, gain_path_on};
  wire sda = sda_m & (sda_oe_n | sda_out);
  integer failures = 0, compares = 0, cycles = 0;
  hpd_core hpd_core_inst (.clk, .reset, .enable_pin, .low_power_hold_pin, .supply_ok,
    .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe_n, .power_mode, .output_hiz, .blocks_on,
    .wake_ready, .gain_path_on);
  hpd_host hpd_host_inst (.scl(scl), .sda_m(sda_m), .sda(sda));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task check(input [7:0] seen, input [7:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
    end
  endtask
  task wrap_up;
    begin
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      failures = failures + 1;
      wrap_up;
    end
  end
  task mode(input e, input h, input s, input [7:0] m, input [7:0] f, input [7:0] k);
    begin
      @(posedge clk) #1;
      enable_pin = e;
      low_power_hold_pin = h;
      supply_ok = s;
      repeat (6) @(posedge clk);
      #1;
      check({6'h0, power_mode}, m);
      check(flags & k, f);
    end
  endtask
  task wr(input [7:0] d, input a);
    begin
      hpd_host_inst.xfer(d, 1'b1, rd, ak);
      check({7'h0, ak}, {7'h0, a});
    end
  endtask
  // write address, pointer, then n data bytes
  task put(input [7:0] p, input [31:0] d, input integer n);
    integer i;
    begin
      @(posedge clk) #1;
      hpd_host_inst.start;
      wr(8'hB4, 1'b0);
      wr(p, 1'b0);
      for (i = 0; i < n; i = i + 1) wr(d[31-8*i -: 8], 1'b0);
      hpd_host_inst.stop;
    end
  endtask
  // pointer write, repeated start, read, last byte refused
  task get(input [7:0] p, input [31:0] d, input integer n);
    integer i;
    begin
      @(posedge clk) #1;
      hpd_host_inst.start;
      wr(8'hB4, 1'b0);
      wr(p, 1'b0);
      hpd_host_inst.start;
      wr(8'hB5, 1'b0);
      for (i = 0; i < n; i = i + 1) begin
        hpd_host_inst.xfer(8'hFF, i == n - 1, rd, ak);
        check(rd, d[31-8*i -: 8]);
      end
      hpd_host_inst.stop;
    end
  endtask
  task t_reset;
    begin
      repeat (20) @(posedge clk);
      check({6'h0, power_mode}, 8'h00);
      check({7'h0, sda_oe_n}, 8'h01);
      #1 reset = 1'b0;
      $display("done reset");
    end
  endtask
  task t_modes;
    begin
      mode(1'b0, 1'b0, 1'b1, 8'h00, 8'h08, 8'h0F);
      mode(1'b1, 1'b1, 1'b1, 8'h01, 8'h02, 8'h07);
      mode(1'b1, 1'b0, 1'b0, 8'h01, 8'h08, 8'h09);
      mode(1'b1, 1'b0, 1'b1, 8'h02, 8'h07, 8'h0F);
      $display("done modes");
    end
  endtask
  task t_burst;
    begin
      put(8'h03, 32'h55AA0F00, 3);
      get(8'h03, 32'h55AA0F00, 4);
      put(8'hFF, 32'hC3000000, 1);
      get(8'hFF, 32'hC3000000, 1);
      $display("done burst");
    end
  endtask
  task t_foreign;
    begin
      @(posedge clk) #1;
      hpd_host_inst.start;
      wr(8'hB6, 1'b1);
      wr(8'h03, 1'b1);
      wr(8'h77, 1'b1);
      hpd_host_inst.stop;
      get(8'h03, 32'h55000000, 1);
      $display("done foreign");
    end
  endtask
  // a power-on reset in mid-run must bring stored bytes back to default
  task t_por;
    begin
      put(8'h07, 32'h5A000000, 1);
      @(posedge clk) #1;
      reset = 1'b1;
      repeat (20) @(posedge clk);
      #1 reset = 1'b0;
      repeat (4) @(posedge clk);
      #1;
      check({6'h0, power_mode}, 8'h02);
      get(8'h07, 32'h00000000, 1);
      $display("done por");
    end
  endtask
  task t_shutdown;
    begin
      mode(1'b0, 1'b0, 1'b1, 8'h00, 8'h08, 8'h0F);
      @(posedge clk) #1;
      hpd_host_inst.start;
      wr(8'hB4, 1'b1);
      hpd_host_inst.stop;
      mode(1'b1, 1'b0, 1'b1, 8'h02, 8'h07, 8'h0F);
      get(8'h03, 32'h00000000, 1);
      $display("done shutdown");
    end
  endtask
  initial begin
    reset = 1'b1;
    enable_pin = 1'b1;
    low_power_hold_pin = 1'b0;
    supply_ok = 1'b1;
    t_reset;
    t_modes;
    t_burst;
    t_foreign;
    t_shutdown;
    t_por;
    wrap_up;
  end
endmodule
`default_nettype wire

/* testbench/hpd_host.sv */
// serial bus controller model; a released data line reads high through the pull-up
`timescale 1ns/1ps
`default_nettype none
module hpd_host (
  output logic scl, // serial clock, rests high
  output logic sda_m, // data drive, 1 releases
  input wire logic sda // resolved data line
);
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task start;
    begin
      #80 sda_m = 1'b1;
      #80 scl = 1'b1;
      #160 sda_m = 1'b0;
      #160 scl = 1'b0;
    end
  endtask
  task stop;
    begin
      #80 sda_m = 1'b0;
      #80 scl = 1'b1;
      #160 sda_m = 1'b1;
      #160;
    end
  endtask
  // data moves only while clock low
  task bitx(input b, output r);
    begin
      #80 sda_m = b;
      #80 scl = 1'b1;
      #80 r = sda;
      #80 scl = 1'b0;
    end
  endtask
  task xfer(input [7:0] d, input a, output [7:0] r, output ra);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) bitx(d[i], r[i]);
      bitx(a, ra);
    end
  endtask
endmodule
`default_nettype wire
